// ===== verilog/rtc_pkg.sv
package rtc_pkg;
   // ==============================================================
   // Widths.
   localparam int CNT_W   = 16;
   localparam int PRESC_W = 10;
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int SRC_W   = 3;
   localparam int FLAG_W  = 2;

   // ==============================================================
   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PRESC  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CNT    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PER    = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CMP    = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CLR    = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_IRQEN  = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_EVTEN  = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_SLEEP  = 8'h24;

   // ==============================================================
   // Field positions.
   localparam int CTRL_EN_BIT  = 0;
   localparam int CTRL_SRC_LSB = 1;
   localparam int FLAG_OVF     = 0;
   localparam int FLAG_CMP     = 1;

   // ==============================================================
   // Reset values.
   localparam logic [CNT_W-1:0]   PER_RST   = 16'hFFFF;
   localparam logic [CNT_W-1:0]   CMP_RST   = 16'h0000;
   localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;
   localparam logic [FLAG_W-1:0]  FLAGS_RST = 2'h0;

   // ==============================================================
   // Crystal tick rates and the divider between them.
   localparam int XTAL_HZ      = 32768;
   localparam int XTAL_SLOW_HZ = 1024;
   localparam int XTAL_DIV     = XTAL_HZ / XTAL_SLOW_HZ;
   localparam int XDIV_W       = $clog2(XTAL_DIV);

   // Reference clock choices.
   typedef enum logic [SRC_W-1:0] {
      SRC_XTAL_SLOW = 3'h0,
      SRC_XTAL_FAST = 3'h1,
      SRC_EXT_CLK   = 3'h2,
      SRC_RC_32K    = 3'h3,
      SRC_LP_32K    = 3'h4
   } src_t;

   // Sleep states announced by the sleep controller.
   typedef enum logic [2:0] {
      SLP_ACTIVE     = 3'h0,
      SLP_IDLE       = 3'h1,
      SLP_POWER_DOWN = 3'h2,
      SLP_POWER_SAVE = 3'h3,
      SLP_STANDBY    = 3'h4,
      SLP_EXT_STBY   = 3'h5
   } sleep_t;
endpackage

// ===== verilog/presc_if.sv
`timescale 1ns/1ps
// Reference ticks in, divider setting in, counter ticks out.
interface presc_if;
   logic                          ref_tick;
   logic [rtc_pkg::PRESC_W-1:0]   div;
   logic                          out_tick;
   modport ctl      (output ref_tick, output div, input out_tick);
   modport divider  (input ref_tick, input div, output out_tick);
endinterface

// ===== verilog/ref_sync.sv
`timescale 1ns/1ps
// Brings an asynchronous reference clock pin into mclk and
// gives a one-cycle pulse on each of its rising edges.
module ref_sync (
   input  logic mclk,
   input  logic rst,
   input  logic pin,
   output logic rise
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // ==============================================================
   // Two-stage synchroniser, then an edge detector on stage two.
   always_ff @(posedge mclk) begin
      if (rst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         last_reg <= 1'b0;
         rise     <= 1'b0;
      end else begin
         meta_reg <= pin;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
         rise     <= sync_reg & ~last_reg;
      end
   end
endmodule

// ===== verilog/rtc_prescaler.sv
`timescale 1ns/1ps
// Divides reference ticks by div+1 and emits one counter tick.
module rtc_prescaler (
   input  logic     mclk,
   input  logic     rst,
   presc_if.divider p
);
   logic [rtc_pkg::PRESC_W-1:0] count_reg;

   // ==============================================================
   // Count reference ticks; the >= guards a setting lowered midway.
   always_ff @(posedge mclk) begin
      if (rst) begin
         count_reg  <= '0;
         p.out_tick <= 1'b0;
      end else if (p.ref_tick) begin
         if (count_reg >= p.div) begin
            count_reg  <= '0;
            p.out_tick <= 1'b1;
         end else begin
            count_reg  <= count_reg + 1'b1;
            p.out_tick <= 1'b0;
         end
      end else begin
         p.out_tick <= 1'b0;
      end
   end
endmodule

// ===== verilog/rtc_counter.sv
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module rtc_counter (
   input  logic                          mclk,
   input  logic                          rst,
   input  logic [rtc_pkg::ADDR_W-1:0]    addr,
   input  logic [rtc_pkg::DATA_W-1:0]    wdata,
   input  logic                          wr,
   input  logic                          rd,
   output logic [rtc_pkg::DATA_W-1:0]    rdata,
   input  logic                          xtal_clk,
   input  logic                          ext_clk,
   input  logic                          rc_32k_clk,
   input  logic                          ultra_low_power_oscillator,
   input  logic [2:0]                    sleep_state,
   output logic                          irq,
   output logic                          evt_ovf,
   output logic                          evt_cmp,
   output logic                          wake
);
   // ==============================================================
   // Declarations.
   logic [rtc_pkg::CNT_W-1:0]   cnt_reg;
   logic [rtc_pkg::CNT_W-1:0]   cnt_next;
   logic [rtc_pkg::CNT_W-1:0]   per_reg;
   logic [rtc_pkg::CNT_W-1:0]   cmp_reg;
   logic [rtc_pkg::PRESC_W-1:0] presc_reg;
   logic                        en_reg;
   logic [rtc_pkg::SRC_W-1:0]   src_reg;
   logic [rtc_pkg::FLAG_W-1:0]  status_reg;
   logic [rtc_pkg::FLAG_W-1:0]  status_next;
   logic [rtc_pkg::FLAG_W-1:0]  irq_en_reg;
   logic [rtc_pkg::FLAG_W-1:0]  evt_en_reg;
   logic [rtc_pkg::FLAG_W-1:0]  clr_mask;
   logic [rtc_pkg::FLAG_W-1:0]  hit_reg;
   logic [rtc_pkg::XDIV_W-1:0]  xdiv_reg;
   logic                        xtal_rise;
   logic                        ext_rise;
   logic                        rc_rise;
   logic                        lp_rise;
   logic                        xtal_slow_tick;
   logic                        ref_tick_sel;
   logic                        clock_alive;
   logic                        cnt_wr;
   logic                        at_period;
   logic                        sleeping;

   presc_if presc ();

   // ==============================================================
   // Reference pins enter the mclk domain through synchronisers.
   ref_sync u_sync_xtal (
      .mclk (mclk),
      .rst  (rst),
      .pin  (xtal_clk),
      .rise (xtal_rise)
   );

   ref_sync u_sync_ext (
      .mclk (mclk),
      .rst  (rst),
      .pin  (ext_clk),
      .rise (ext_rise)
   );

   ref_sync u_sync_rc (
      .mclk (mclk),
      .rst  (rst),
      .pin  (rc_32k_clk),
      .rise (rc_rise)
   );

   ref_sync u_sync_lp (
      .mclk (mclk),
      .rst  (rst),
      .pin  (ultra_low_power_oscillator),
      .rise (lp_rise)
   );

   // ==============================================================
   // Crystal divider producing the slow low-power tick.
   always_ff @(posedge mclk) begin
      if (rst) begin
         xdiv_reg       <= '0;
         xtal_slow_tick <= 1'b0;
      end else if (xtal_rise) begin
         xdiv_reg       <= xdiv_reg + 1'b1;
         xtal_slow_tick <= (xdiv_reg == '1);
      end else begin
         xtal_slow_tick <= 1'b0;
      end
   end

   // ==============================================================
   // Sleep handling.

   // The oscillators stop only in power-down and standby.
   always_comb begin
      case (rtc_pkg::sleep_t'(sleep_state))
         rtc_pkg::SLP_POWER_DOWN: clock_alive = 1'b0;
         rtc_pkg::SLP_STANDBY:    clock_alive = 1'b0;
         rtc_pkg::SLP_POWER_SAVE: clock_alive = 1'b1;
         rtc_pkg::SLP_EXT_STBY:   clock_alive = 1'b1;
         default:                 clock_alive = 1'b1;
      endcase
   end

   // Any state other than active counts as asleep.
   assign sleeping = (sleep_state != rtc_pkg::SLP_ACTIVE);

   // ==============================================================
   // Reference selection.

   // The chosen source feeds the prescaler while counting runs.
   always_comb begin
      case (rtc_pkg::src_t'(src_reg))
         rtc_pkg::SRC_XTAL_SLOW: ref_tick_sel = xtal_slow_tick;
         rtc_pkg::SRC_XTAL_FAST: ref_tick_sel = xtal_rise;
         rtc_pkg::SRC_EXT_CLK:   ref_tick_sel = ext_rise;
         rtc_pkg::SRC_RC_32K:    ref_tick_sel = rc_rise;
         rtc_pkg::SRC_LP_32K:    ref_tick_sel = lp_rise;
         default:                ref_tick_sel = 1'b0;
      endcase
   end

   // Prescaler hookup.
   assign presc.ref_tick = ref_tick_sel & en_reg & clock_alive;
   assign presc.div      = presc_reg;

   rtc_prescaler u_presc (
      .mclk (mclk),
      .rst  (rst),
      .p    (presc)
   );

   // ==============================================================
   // Configuration registers.

   // Control word: enable and reference choice.
   always_ff @(posedge mclk) begin
      if (rst) begin
         en_reg  <= 1'b0;
         src_reg <= rtc_pkg::SRC_XTAL_SLOW;
      end else if (wr && addr == rtc_pkg::OFS_CTRL) begin
         en_reg  <= wdata[rtc_pkg::CTRL_EN_BIT];
         src_reg <= wdata[rtc_pkg::CTRL_SRC_LSB +: rtc_pkg::SRC_W];
      end
   end

   // Prescaler setting.
   always_ff @(posedge mclk) begin
      if (rst) begin
         presc_reg <= rtc_pkg::PRESC_RST;
      end else if (wr && addr == rtc_pkg::OFS_PRESC) begin
         presc_reg <= wdata[rtc_pkg::PRESC_W-1:0];
      end
   end

   // Period and compare values.
   always_ff @(posedge mclk) begin
      if (rst) begin
         per_reg <= rtc_pkg::PER_RST;
         cmp_reg <= rtc_pkg::CMP_RST;
      end else if (wr) begin
         if (addr == rtc_pkg::OFS_PER) begin
            per_reg <= wdata;
         end
         if (addr == rtc_pkg::OFS_CMP) begin
            cmp_reg <= wdata;
         end
      end
   end

   // Interrupt and event enables.
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_en_reg <= rtc_pkg::FLAGS_RST;
         evt_en_reg <= rtc_pkg::FLAGS_RST;
      end else if (wr) begin
         if (addr == rtc_pkg::OFS_IRQEN) begin
            irq_en_reg <= wdata[rtc_pkg::FLAG_W-1:0];
         end
         if (addr == rtc_pkg::OFS_EVTEN) begin
            evt_en_reg <= wdata[rtc_pkg::FLAG_W-1:0];
         end
      end
   end

   // ==============================================================
   // The counter.

   // A software write to the count wins over a tick.
   assign cnt_wr    = wr && (addr == rtc_pkg::OFS_CNT);
   assign at_period = (cnt_reg == per_reg);

   // Step by one, or wrap to zero at the period value.
   always_comb begin
      if (at_period) begin
         cnt_next = '0;
      end else begin
         cnt_next = cnt_reg + 1'b1;
      end
   end

   // Count register.
   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt_reg <= '0;
      end else if (cnt_wr) begin
         cnt_reg <= wdata;
      end else if (presc.out_tick) begin
         cnt_reg <= cnt_next;
      end
   end

   // Matches are caught on the tick and held one cycle.
   always_ff @(posedge mclk) begin
      if (rst) begin
         hit_reg <= '0;
      end else begin
         hit_reg[rtc_pkg::FLAG_OVF] <=
            presc.out_tick & ~cnt_wr & at_period;
         hit_reg[rtc_pkg::FLAG_CMP] <=
            presc.out_tick & ~cnt_wr & (cnt_next == cmp_reg);
      end
   end

   // ==============================================================
   // Status flags, interrupt, events and wake.

   // Write-one-to-clear mask from the clear register.
   always_comb begin
      clr_mask = '0;
      if (wr && addr == rtc_pkg::OFS_CLR) begin
         clr_mask = wdata[rtc_pkg::FLAG_W-1:0];
      end
   end

   // A match in the clearing cycle keeps its flag set.
   assign status_next = (status_reg & ~clr_mask) | hit_reg;

   // Sticky flags.
   always_ff @(posedge mclk) begin
      if (rst) begin
         status_reg <= rtc_pkg::FLAGS_RST;
      end else begin
         status_reg <= status_next;
      end
   end

   // Level interrupt while an enabled flag stands.
   always_ff @(posedge mclk) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_next & irq_en_reg);
      end
   end

   // One-cycle event pulses for the event system.
   always_ff @(posedge mclk) begin
      if (rst) begin
         evt_ovf <= 1'b0;
         evt_cmp <= 1'b0;
      end else begin
         evt_ovf <= hit_reg[rtc_pkg::FLAG_OVF]
                    & evt_en_reg[rtc_pkg::FLAG_OVF];
         evt_cmp <= hit_reg[rtc_pkg::FLAG_CMP]
                    & evt_en_reg[rtc_pkg::FLAG_CMP];
      end
   end

   // Wake request while asleep and an enabled source has fired.
   always_ff @(posedge mclk) begin
      if (rst) begin
         wake <= 1'b0;
      end else begin
         wake <= sleeping
                 & |(status_next & (irq_en_reg | evt_en_reg));
      end
   end

   // ==============================================================
   // Read port; data stand in the cycle after the strobe only.
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd) begin
         case (addr)
            rtc_pkg::OFS_CTRL: begin
               rdata <= {12'h000, src_reg, en_reg};
            end
            rtc_pkg::OFS_PRESC: begin
               rdata <= {6'h00, presc_reg};
            end
            rtc_pkg::OFS_CNT: begin
               rdata <= cnt_reg;
            end
            rtc_pkg::OFS_PER: begin
               rdata <= per_reg;
            end
            rtc_pkg::OFS_CMP: begin
               rdata <= cmp_reg;
            end
            rtc_pkg::OFS_STATUS: begin
               rdata <= {14'h0000, status_reg};
            end
            rtc_pkg::OFS_IRQEN: begin
               rdata <= {14'h0000, irq_en_reg};
            end
            rtc_pkg::OFS_EVTEN: begin
               rdata <= {14'h0000, evt_en_reg};
            end
            rtc_pkg::OFS_SLEEP: begin
               rdata <= {13'h0000, sleep_state};
            end
            default: begin
               rdata <= '0;
            end
         endcase
      end else begin
         rdata <= '0;
      end
   end
endmodule

// ===== tb/ref_osc_model.sv
`timescale 1ns/1ps
// ============================================================
// Reference oscillator pins that feed the counter.
module ref_osc_model (
   output logic xtal_clk,
   output logic ext_clk,
   output logic rc_32k_clk,
   output logic ultra_low_power_oscillator
);
   logic [3:0] pins;

   // Every pin idles low so only the burst edges can be counted.
   initial pins = 4'h0;

   // One pin for each reference oscillator; both crystal choices share pins[0].
   assign xtal_clk                   = pins[0];
   assign ext_clk                    = pins[1];
   assign rc_32k_clk                 = pins[2];
   assign ultra_low_power_oscillator = pins[3];

   // Sends n rising edges on one pin, unrelated in phase to mclk.
   task automatic pulse(input int pin, input int n);
      repeat (n) begin
         #61;
         pins[pin] = 1'b1;
         #61;
         pins[pin] = 1'b0;
      end
   endtask
endmodule

// ===== tb/rtc_monitor.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the counter block.
module rtc_monitor (
   input logic                       mclk,
   input logic                       rst,
   input logic [rtc_pkg::ADDR_W-1:0] addr,
   input logic [rtc_pkg::DATA_W-1:0] wdata,
   input logic                       wr,
   input logic                       rd,
   input logic [rtc_pkg::DATA_W-1:0] rdata,
   input logic                       xtal_clk,
   input logic                       ext_clk,
   input logic                       rc_32k_clk,
   input logic                       ultra_low_power_oscillator,
   input logic [2:0]                 sleep_state,
   input logic                       irq,
   input logic                       evt_ovf,
   input logic                       evt_cmp,
   input logic                       wake
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // Events are single-cycle pulses.
   evt_ovf_pulse_a: assert property (evt_ovf |=> !evt_ovf)
      else $error("overflow event longer than one cycle");
   evt_cmp_pulse_a: assert property (evt_cmp |=> !evt_cmp)
      else $error("compare event longer than one cycle");
   // Wake is only raised while the device sleeps.
   wake_when_asleep_a: assert property (wake
      |-> $past(sleep_state) != 3'h0)
      else $error("wake raised while active");
   // Clearing the interrupt enables drops the interrupt line.
   irq_mask_a: assert property ((wr && addr == rtc_pkg::OFS_IRQEN
      && wdata == 16'h0000) |=> ##1 !irq)
      else $error("interrupt stays high with enables cleared");
   // Count, period and prescaler read back at once, also back to back; the sleep state reads back too.
   cnt_readback_a: assert property ((wr && addr == rtc_pkg::OFS_CNT ##1
      rd && addr == rtc_pkg::OFS_CNT) |=> rdata == $past(wdata, 2))
      else $error("count readback differs from written value");
   per_readback_a: assert property ((wr && addr == rtc_pkg::OFS_PER ##1
      rd && addr == rtc_pkg::OFS_PER) |=> rdata == $past(wdata, 2))
      else $error("period readback differs from written value");
   presc_readback_a: assert property ((wr
      && addr == rtc_pkg::OFS_PRESC ##1 rd && addr == rtc_pkg::OFS_PRESC)
      |=> rdata == ($past(wdata, 2) & 16'h03FF))
      else $error("prescaler readback is not ten bits of the write");
   sleep_readback_a: assert property (($past(rd)
      && $past(addr) == rtc_pkg::OFS_SLEEP)
      |-> rdata == {13'h0000, $past(sleep_state)})
      else $error("sleep state readback wrong");
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin \
   n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
// ============================================================
// Register-level tests of the counter block.
module testbench;
   logic                       mclk;
   logic                       rst;
   logic [rtc_pkg::ADDR_W-1:0] addr;
   logic [rtc_pkg::DATA_W-1:0] wdata;
   logic [rtc_pkg::DATA_W-1:0] rdata;
   logic                       wr;
   logic                       rd;
   logic                       xtal_clk;
   logic                       ext_clk;
   logic                       rc_32k_clk;
   logic                       lp_osc_clk;
   logic [2:0]                 sleep_state;
   logic                       irq;
   logic                       evt_ovf;
   logic                       evt_cmp;
   logic                       wake;
   int                         n_mismatch = 0;
   int                         n_tests = 0;
   int                         n_ovf = 0;
   int                         n_cmp = 0;
   // Source, pin, prescaler, edges sent and expected count per row.
   int t_src[7] = '{0, 1, 2, 3, 4, 4, 5};
   int t_pin[7] = '{0, 0, 1, 2, 3, 0, 3};
   int t_p[7]   = '{0, 0, 3, 1023, 1, 0, 0};
   int t_n[7]   = '{64, 5, 10, 1024, 7, 5, 3};
   int t_e[7]   = '{2, 5, 2, 1, 3, 0, 0};

   rtc_counter i_dut (
      .mclk                       (mclk),
      .rst                        (rst),
      .addr                       (addr),
      .wdata                      (wdata),
      .wr                         (wr),
      .rd                         (rd),
      .rdata                      (rdata),
      .xtal_clk                   (xtal_clk),
      .ext_clk                    (ext_clk),
      .rc_32k_clk                 (rc_32k_clk),
      .ultra_low_power_oscillator (lp_osc_clk),
      .sleep_state                (sleep_state),
      .irq                        (irq),
      .evt_ovf                    (evt_ovf),
      .evt_cmp                    (evt_cmp),
      .wake                       (wake)
   );

   ref_osc_model i_osc (
      .xtal_clk                   (xtal_clk),
      .ext_clk                    (ext_clk),
      .rc_32k_clk                 (rc_32k_clk),
      .ultra_low_power_oscillator (lp_osc_clk)
   );

   // The 100 MHz system clock.
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Event pulses are counted away from the launching edge.
   always @(negedge mclk) begin
      if (evt_ovf === 1'b1) n_ovf++;
      if (evt_cmp === 1'b1) n_cmp++;
   end

   task automatic rst_dut;
      rst <= 1'b1;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [15:0] e,
                         input string m);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e, m)
   endtask

   // A write followed at once by a read of the same register.
   task automatic wr_rd(input logic [7:0] a, input logic [15:0] v,
                        input logic [15:0] e, input string m);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      `CHK(rdata, e, m)
   endtask

   // Sends edges on one reference pin and lets the count settle.
   task automatic burst(input int pin, input int n);
      i_osc.pulse(pin, n);
      idle(12);
   endtask

   task automatic set_sleep(input logic [2:0] s);
      @(posedge mclk);
      sleep_state <= s;
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // A hung run is cut short and judged as failed.
   initial begin
      #400000;
      n_mismatch++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      finish_test;
   end

   // The test sequence.
   initial begin
      rst = 1'b1;
      addr = 8'h00;
      wdata = 16'h0000;
      wr = 1'b0;
      rd = 1'b0;
      sleep_state = 3'h0;
      rst_dut;
      rd_chk(rtc_pkg::OFS_PER, 16'hFFFF, "period reset");
      rd_chk(rtc_pkg::OFS_CMP, 16'h0000, "compare reset");
      rd_chk(rtc_pkg::OFS_PRESC, 16'h0000, "prescaler reset");
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0000, "status reset");
      rd_chk(8'h30, 16'h0000, "unmapped read");
      wr_rd(rtc_pkg::OFS_CNT, 16'hA5C3, 16'hA5C3, "count write");
      wr_rd(rtc_pkg::OFS_PRESC, 16'hFFFF, 16'h03FF, "presc width");
      wr_rd(rtc_pkg::OFS_PER, 16'h8001, 16'h8001, "period write");
      $display("test registers done");
      for (int i = 0; i < 7; i++) begin
         rst_dut;
         wr_reg(rtc_pkg::OFS_PRESC, 16'(t_p[i]));
         wr_reg(rtc_pkg::OFS_CTRL, 16'(t_src[i] * 2 + 1));
         burst(t_pin[i], t_n[i]);
         rd_chk(rtc_pkg::OFS_CNT, 16'(t_e[i]), "count");
      end
      $display("test sources done");
      rst_dut;
      wr_reg(rtc_pkg::OFS_PER, 16'h0002);
      wr_reg(rtc_pkg::OFS_CMP, 16'h0001);
      wr_reg(rtc_pkg::OFS_EVTEN, 16'h0003);
      wr_reg(rtc_pkg::OFS_CTRL, 16'h0009);
      burst(3, 1);
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0002, "compare flag");
      `CHK(irq, 1'b0, "irq while masked")
      wr_reg(rtc_pkg::OFS_IRQEN, 16'h0002);
      idle(2);
      `CHK(irq, 1'b1, "compare irq")
      burst(3, 2);
      rd_chk(rtc_pkg::OFS_CNT, 16'h0000, "wrap to zero");
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0003, "overflow flag");
      `CHK(n_cmp, 1, "compare events")
      `CHK(n_ovf, 1, "overflow events")
      wr_reg(rtc_pkg::OFS_STATUS, 16'h0000);
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0003, "status is read-only");
      wr_reg(rtc_pkg::OFS_CLR, 16'h0002);
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0001, "compare cleared");
      `CHK(irq, 1'b0, "irq after clear")
      wr_reg(rtc_pkg::OFS_IRQEN, 16'h0001);
      idle(2);
      `CHK(irq, 1'b1, "overflow irq")
      wr_reg(rtc_pkg::OFS_IRQEN, 16'h0000);
      idle(2);
      `CHK(irq, 1'b0, "irq disabled")
      wr_reg(rtc_pkg::OFS_CLR, 16'h0001);
      rd_chk(rtc_pkg::OFS_STATUS, 16'h0000, "all cleared");
      $display("test events done");
      wr_reg(rtc_pkg::OFS_IRQEN, 16'h0002);
      wr_reg(rtc_pkg::OFS_EVTEN, 16'h0001);
      set_sleep(rtc_pkg::SLP_POWER_DOWN);
      burst(3, 3);
      rd_chk(rtc_pkg::OFS_CNT, 16'h0000, "held in power-down");
      set_sleep(rtc_pkg::SLP_STANDBY);
      burst(3, 2);
      rd_chk(rtc_pkg::OFS_CNT, 16'h0000, "held in standby");
      set_sleep(rtc_pkg::SLP_POWER_SAVE);
      burst(3, 1);
      rd_chk(rtc_pkg::OFS_CNT, 16'h0001, "runs in power-save");
      `CHK(wake, 1'b1, "wake on compare")
      set_sleep(rtc_pkg::SLP_EXT_STBY);
      burst(3, 1);
      rd_chk(rtc_pkg::OFS_CNT, 16'h0002, "runs in ext standby");
      rd_chk(rtc_pkg::OFS_SLEEP, 16'h0005, "sleep readback");
      set_sleep(rtc_pkg::SLP_ACTIVE);
      idle(2);
      `CHK(wake, 1'b0, "no wake when active")
      `CHK(irq, 1'b1, "irq while active")
      `CHK(n_cmp, 1, "compare event masked")
      $display("test sleep done");
      finish_test;
   end
endmodule

bind rtc_counter rtc_monitor i_mon (
   .mclk                       (mclk),
   .rst                        (rst),
   .addr                       (addr),
   .wdata                      (wdata),
   .wr                         (wr),
   .rd                         (rd),
   .rdata                      (rdata),
   .xtal_clk                   (xtal_clk),
   .ext_clk                    (ext_clk),
   .rc_32k_clk                 (rc_32k_clk),
   .ultra_low_power_oscillator (ultra_low_power_oscillator),
   .sleep_state                (sleep_state),
   .irq                        (irq),
   .evt_ovf                    (evt_ovf),
   .evt_cmp                    (evt_cmp),
   .wake                       (wake)
);
